// ### verilog/pic_regs.svh
// Register addresses, field positions, reset values and timing counts of the interrupt controller.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

`define PIC_ADDR_ENABLE_EXT   8'h2c
`define PIC_ADDR_PENDING_EXT  8'h2e
`define PIC_ADDR_ENABLE_LOW   8'h3a
`define PIC_ADDR_ENABLE_HIGH  8'h3b
`define PIC_ADDR_PENDING_LOW  8'h3c
`define PIC_ADDR_PENDING_HIGH 8'h3d

`define PIC_NUM_SOURCES       24
`define PIC_FIRST_LATCH       2
`define PIC_FIRST_MASKABLE    4
`define PIC_LAST_SOURCE       23
`define PIC_BIT_ADDR_TRAP     2
`define PIC_BIT_WDOG          3
`define PIC_BIT_EXT0          4
`define PIC_BIT_MASTER        0
`define PIC_IDX_SOFT_TRAP     5'h01

`define PIC_VEC_BASE_LO       16'hfffe
`define PIC_VEC_BASE_HI       16'hffde
`define PIC_VEC_SPLIT         5'h10

`define PIC_RESET_LATCH       22'h000000
`define PIC_RESET_ENABLE      20'h00000
`define PIC_RESET_MASTER      1'h0

`define PIC_ACCEPT_MCYC       8
`define PIC_MCYC_CLKS         4
`define PIC_PUSH_BYTES        3

`endif

// ### verilog/pic_pkg.sv
// Types shared by the interrupt controller modules.
package pic_pkg;
    typedef enum logic [0:0] {
        PIC_IDLE,
        PIC_SEQ
    } pic_state_t;
    typedef logic [23:2] pic_latch_t;
    typedef logic [23:4] pic_enable_t;
    typedef logic [4:0]  pic_idx_t;
endpackage

// ### verilog/pic_arb_if.sv
// Signals between the controller core and its priority arbiter.
`timescale 1ns/1ps
interface pic_arb_if;
    import pic_pkg::*;
    pic_latch_t  pending;
    pic_enable_t enable;
    logic        master;
    logic        pin_en;
    logic        soft_req;
    logic        win_valid;
    logic        win_maskable;
    pic_idx_t    win_idx;
    logic [15:0] win_vec;
    modport ctrl (output pending, enable, master, pin_en, soft_req,
                  input win_valid, win_maskable, win_idx, win_vec);
    modport arb  (input pending, enable, master, pin_en, soft_req,
                  output win_valid, win_maskable, win_idx, win_vec);
endinterface

// ### verilog/pic_arbiter.sv
// Fixed-priority arbiter that picks the winning source and its vector.
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_arbiter
    import pic_pkg::*;
(
    pic_arb_if.arb arb
);
    pic_latch_t req;

    // Non-maskable latches pass ungated; maskable ones need the master and their own enable.
    genvar g;
    generate
        for (g = `PIC_FIRST_LATCH; g <= `PIC_LAST_SOURCE; g = g + 1) begin : g_req
            if (g < `PIC_FIRST_MASKABLE) begin : g_nmi
                assign req[g] = arb.pending[g]; // RL18
            end else if (g == `PIC_BIT_EXT0) begin : g_ext0
                assign req[g] = arb.pending[g] & arb.master & arb.enable[g] & arb.pin_en; // RL7
            end else begin : g_mask
                assign req[g] = arb.pending[g] & arb.master & arb.enable[g]; // RL8 RL20
            end
        end
    endgenerate

    function automatic logic [15:0] pic_vector(input pic_idx_t idx);
        logic [15:0] off;
        off = {10'h000, idx, 1'b0};
        if (idx < `PIC_VEC_SPLIT) begin
            pic_vector = `PIC_VEC_BASE_LO - off;
        end else begin
            pic_vector = `PIC_VEC_BASE_HI - off;
        end
    endfunction

    // Lowest index wins; the software and illegal-opcode traps share one vector and sit first.
    always_comb begin
        pic_idx_t idx;
        logic     found;
        idx   = 5'h00;
        found = 1'b0;
        if (arb.soft_req) begin
            idx   = `PIC_IDX_SOFT_TRAP; // RL5 RL4
            found = 1'b1;
        end
        for (int i = `PIC_LAST_SOURCE; i >= `PIC_FIRST_LATCH; i--) begin
            if (req[i] && !arb.soft_req) begin
                idx   = 5'(i); // RL3
                found = 1'b1;
            end
        end
        arb.win_valid    = found;
        arb.win_idx      = idx;
        arb.win_maskable = found && (idx >= 5'(`PIC_FIRST_MASKABLE));
        arb.win_vec      = pic_vector(idx); // RL1 RL6
    end
endmodule

// ### verilog/pic_ctrl.sv
// Vectored fixed-priority interrupt controller: latches, enables, master flag and acceptance sequence.
// Overview of operation
// (RL1) Twenty-four sources besides reset on twenty-three vectors; nesting by priority.
// (RL2) Software, illegal-opcode, address and watchdog traps are non-maskable; others are maskable.
// (RL3) Simultaneous enabled requests are taken lowest priority number first.
// (RL4) Non-maskable sources share priority level 2 with no ranking among them; the code ranks software/illegal-opcode traps, then address trap, then watchdog.
// (RL5) Software and illegal-opcode traps have no latch and vector to FFFC.
// (RL6) Address trap uses latch bit 2, vector FFFA; watchdog bit 3, FFF8.
// (RL7) External source 0 needs master, enable bit 4 and pin enable; vector FFF6.
// (RL8) A maskable request needs its latch, its enable and the master enable.
// (RL9) A latch sets on its source's request and holds until accepted or cleared.
// (RL10) Acceptance clears the accepted source's latch at once.
// (RL11) Reset clears every latch.
// (RL12) Latches sit at 002E, 003C, 003D; writing 0 clears a bit.
// (RL13) Software writes 1 to the address-trap and watchdog latch bits.
// (RL14) Software clears latches by whole-register loads only.
// (RL15) Writing 1 to a latch bit does nothing; only hardware sets latches.
// (RL16) Latches read back the current request state of every source; the code has no read-back for the software and illegal-opcode traps.
// (RL17) Software clears the master around enable or latch changes in main code.
// (RL18) Non-maskable sources ignore the master and individual enables.
// (RL19) Enables sit at 002C, 003A, 003B and are fully readable and writable.
// (RL20) With the master clear no maskable interrupt is accepted.
// (RL21) Acceptance saves the master then clears it; either return restores it.
// (RL22) Master is bit 0 at 003A, set and cleared by instructions, reset to 0.
// (RL23) Trap and watchdog events give a reset while their routing select is set.
// (RL24) The acceptance sequence takes eight machine cycles.
// (RL25) Acceptance pushes status with master, PC high, PC low; stack drops by three.
// (RL26) Reset clears all individual enables.
// (RL27) The winning vector is a registered output, stable through the sequence.
// (RL28) A hardware set in the same cycle as a clear leaves the latch set.
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_ctrl
    import pic_pkg::*;
#(
    parameter int MCYC_CLKS = `PIC_MCYC_CLKS
)(
    // Clock, reset and clock enable.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Special-function register port.
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // Interrupt sources.
    input  wire logic [23:4] src_irq,
    input  wire logic        addr_trap_irq,
    input  wire logic        wdog_irq,
    input  wire logic        soft_trap_irq,
    input  wire logic        illegal_opcode_irq,
    input  wire logic        ext0_pin_enable,
    input  wire logic        addr_trap_route_sel,
    input  wire logic        wdog_route_sel,
    // Processor core handshake.
    input  wire logic        core_take,
    input  wire logic        set_master_op,
    input  wire logic        clear_master_op,
    input  wire logic        maskable_return_op,
    input  wire logic        nonmaskable_return_op,
    input  wire logic        restored_master,
    output logic             core_irq_req,
    output logic      [15:0] core_vector,
    output logic             accept_busy,
    output logic      [1:0]  push_sel,
    output logic             sp_dec,
    output logic             status_master,
    output logic             malfunction_reset
);
    localparam int ACC_CLKS = `PIC_ACCEPT_MCYC * MCYC_CLKS;
    localparam int PUSH_CLKS = `PIC_PUSH_BYTES * MCYC_CLKS;
    localparam int BUSY_CLKS = ACC_CLKS + 1;

    generate
        if (MCYC_CLKS < 1 || MCYC_CLKS > 16) begin : g_bad_mcyc
            $error("pic_ctrl: MCYC_CLKS must lie between 1 and 16");
        end
    endgenerate

    pic_arb_if arb ();

    pic_arbiter u_arbiter (
        .arb (arb)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Latches, enables and master flag.

    pic_latch_t  pending;
    pic_latch_t  next_pending;
    pic_enable_t enable;
    pic_enable_t next_enable;
    logic        master;
    logic        next_master;
    logic        reset_req;
    logic        next_reset_req;
    pic_latch_t  hw_set;
    pic_latch_t  sw_keep;
    pic_latch_t  acc_clr;
    logic        accept;
    pic_state_t  state;
    pic_state_t  next_state;

    assign accept = ce && state == PIC_IDLE && core_take && arb.win_valid;

    always_comb begin
        // Routed traps become a reset request instead of setting their latch.
        hw_set        = {src_irq, wdog_irq && !wdog_route_sel, addr_trap_irq && !addr_trap_route_sel}; // RL23 RL9
        next_reset_req = (addr_trap_irq && addr_trap_route_sel) || (wdog_irq && wdog_route_sel); // RL23
        sw_keep = '1;
        if (sfr_wr) begin
            case (sfr_addr)
                `PIC_ADDR_PENDING_EXT:  sw_keep[23:16] = sfr_wdata; // RL12
                `PIC_ADDR_PENDING_HIGH: sw_keep[15:8]  = sfr_wdata; // RL12
                `PIC_ADDR_PENDING_LOW:  sw_keep[7:2]   = sfr_wdata[7:2]; // RL12 RL13
                default:                sw_keep        = '1;
            endcase
        end
        acc_clr = '0;
        if (accept && arb.win_idx >= 5'(`PIC_FIRST_LATCH)) begin
            acc_clr[arb.win_idx] = 1'b1; // RL10
        end
        // Ones written only keep; a hardware set beats any clear in the same cycle.
        next_pending = (pending & sw_keep & ~acc_clr) | hw_set; // RL15 RL28

        next_enable = enable;
        if (sfr_wr) begin
            case (sfr_addr)
                `PIC_ADDR_ENABLE_EXT:  next_enable[23:16] = sfr_wdata; // RL19
                `PIC_ADDR_ENABLE_HIGH: next_enable[15:8]  = sfr_wdata; // RL19
                `PIC_ADDR_ENABLE_LOW:  next_enable[7:4]   = sfr_wdata[7:4]; // RL19
                default:               next_enable        = enable;
            endcase
        end

        next_master = master;
        if (accept) begin
            next_master = 1'b0; // RL21
        end else if (maskable_return_op || nonmaskable_return_op) begin
            next_master = restored_master; // RL21
        end else if (set_master_op) begin
            next_master = 1'b1; // RL22
        end else if (clear_master_op) begin
            next_master = 1'b0; // RL22
        end else if (sfr_wr && sfr_addr == `PIC_ADDR_ENABLE_LOW) begin
            next_master = sfr_wdata[`PIC_BIT_MASTER]; // RL22
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending   <= `PIC_RESET_LATCH; // RL11
            enable    <= `PIC_RESET_ENABLE; // RL26
            master    <= `PIC_RESET_MASTER; // RL22
            reset_req <= 1'b0;
        end else if (ce) begin
            pending   <= next_pending;
            enable    <= next_enable;
            master    <= next_master;
            reset_req <= next_reset_req;
        end
    end

    assign malfunction_reset = reset_req;

    assign arb.pending  = pending;
    assign arb.enable   = enable;
    assign arb.master   = master;
    assign arb.pin_en   = ext0_pin_enable;
    assign arb.soft_req = soft_trap_irq || illegal_opcode_irq; // RL2 RL5

    ////////////////////////////////////////////////////////////////////////////////
    // Register read-back.

    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                `PIC_ADDR_ENABLE_EXT:   next_rdata = enable[23:16]; // RL19
                `PIC_ADDR_ENABLE_HIGH:  next_rdata = enable[15:8];
                `PIC_ADDR_ENABLE_LOW:   next_rdata = {enable[7:4], 3'h0, master};
                `PIC_ADDR_PENDING_EXT:  next_rdata = pending[23:16]; // RL16
                `PIC_ADDR_PENDING_HIGH: next_rdata = pending[15:8];
                `PIC_ADDR_PENDING_LOW:  next_rdata = {pending[7:2], 2'h0};
                default:                next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (ce) begin
            sfr_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Acceptance sequence.

    logic [7:0]  seq_cnt;
    logic [7:0]  next_seq_cnt;
    logic [15:0] next_vector;
    logic        next_req;
    logic        next_status_master;
    logic [1:0]  next_push_sel;
    logic        next_sp_dec;

    always_comb begin
        next_state         = state;
        next_seq_cnt       = seq_cnt;
        next_vector        = core_vector;
        next_status_master = status_master;
        next_req           = 1'b0;
        next_push_sel      = 2'h0;
        next_sp_dec        = 1'b0;
        case (state)
            PIC_IDLE: begin
                next_req = arb.win_valid && !accept;
                if (accept) begin
                    next_state         = PIC_SEQ;
                    next_seq_cnt       = 8'h00;
                    next_vector        = arb.win_vec; // RL27
                    next_status_master = master; // RL21 RL25
                    next_push_sel      = 2'h1; // RL25
                    next_sp_dec        = 1'b1;
                end
            end
            PIC_SEQ: begin
                next_seq_cnt = seq_cnt + 8'h01;
                if (int'(next_seq_cnt) % MCYC_CLKS == 0 && int'(next_seq_cnt) < PUSH_CLKS) begin
                    next_push_sel = push_sel == 2'h0 ? 2'h0 : push_sel;
                    next_push_sel = 2'(int'(next_seq_cnt) / MCYC_CLKS + 1); // RL25
                    next_sp_dec   = 1'b1;
                end else if (int'(next_seq_cnt) < PUSH_CLKS) begin
                    next_push_sel = push_sel;
                end
                if (int'(next_seq_cnt) >= ACC_CLKS) begin
                    next_state = PIC_IDLE; // RL24
                end
            end
            default: begin
                next_state = PIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= PIC_IDLE;
            seq_cnt       <= 8'h00;
            core_vector   <= 16'h0000;
            core_irq_req  <= 1'b0;
            status_master <= 1'b0;
            push_sel      <= 2'h0;
            sp_dec        <= 1'b0;
            accept_busy   <= 1'b0;
        end else if (ce) begin
            state         <= next_state;
            seq_cnt       <= next_seq_cnt;
            core_vector   <= next_vector;
            core_irq_req  <= next_req;
            status_master <= next_status_master;
            push_sel      <= next_push_sel;
            sp_dec        <= next_sp_dec;
            accept_busy   <= next_state == PIC_SEQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !ce);

    a_vector_stable: // RL27
    assert property (accept_busy && $past(accept_busy) |-> $stable(core_vector))
        else $error("vector changed during acceptance");

    a_accept_master: // RL21
    assert property (accept |=> !master && status_master == $past(master))
        else $error("master not saved and cleared on acceptance");

    a_master_gate: // RL20
    assert property (accept && arb.win_maskable |-> master)
        else $error("maskable source accepted with master clear");

    a_busy_hold: // RL24
    assert property (accept |=> accept_busy [*8])
        else $error("acceptance sequence ended early");

    a_busy_end: // RL24
    assert property (accept |-> ##BUSY_CLKS !accept_busy)
        else $error("acceptance sequence overran");

    a_latch_cleared: // RL10
    assert property (accept && arb.win_idx >= 5'h02 && !hw_set[arb.win_idx]
                     |=> !pending[$past(arb.win_idx)])
        else $error("accepted latch not cleared");

    a_set_wins: // RL28
    assert property (src_irq[5] |=> pending[5])
        else $error("hardware set lost to a clear");

    a_write_no_set: // RL15
    assert property (sfr_wr && sfr_addr == `PIC_ADDR_PENDING_HIGH && hw_set[15:8] == 8'h00 && !accept
                     |=> pending[15:8] == ($past(pending[15:8]) & $past(sfr_wdata)))
        else $error("latch write did not clear-only");

    a_trap_reset: // RL23
    assert property (addr_trap_irq && addr_trap_route_sel |=> malfunction_reset && !pending[2])
        else $error("routed address trap gave no reset");

    a_push_count: // RL25
    assert property (accept |-> sp_dec == 1'b0 ##1 sp_dec ##MCYC_CLKS sp_dec ##MCYC_CLKS sp_dec)
        else $error("stack not decremented three times");
endmodule

// ### sim/pic_core_model.sv
// Processor core model that takes every offered interrupt and records each acceptance sequence.
`timescale 1ns/1ps
module pic_core_model (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Controller outputs seen by the core.
    input  wire logic       core_irq_req,
    input  wire logic       accept_busy,
    input  wire logic [1:0] push_sel,
    input  wire logic       sp_dec,
    // Take pulse and sequence records.
    output logic            core_take,
    output logic [7:0]      busy_cycles,
    output logic [7:0]      push_count,
    output logic [5:0]      push_order
);
    // The take is a one-cycle pulse, never offered while a sequence runs.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_take   <= 1'b0;
            busy_cycles <= 8'h00;
            push_count  <= 8'h00;
            push_order  <= 6'h00;
        end else begin
            core_take <= core_irq_req && !accept_busy && !core_take;
            if (core_take) begin
                busy_cycles <= 8'h00;
                push_count  <= 8'h00;
                push_order  <= 6'h00;
            end else begin
                if (accept_busy) begin
                    busy_cycles <= busy_cycles + 8'h01;
                end
                if (sp_dec) begin
                    push_count <= push_count + 8'h01;
                    push_order <= {push_order[3:0], push_sel};
                end
            end
        end
    end
endmodule

// ### sim/priority_interrupt_controller_bench.sv
// Self-checking bench for the interrupt controller with a core model on its far side.
`timescale 1ns/1ps
module priority_interrupt_controller_bench;
    import pic_pkg::*;
    localparam int MC = 2;
    typedef struct {int kind; int idx; logic [7:0] en_addr; logic [7:0] en_data; logic [15:0] vec;} pic_row_t;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic [19:0] src_irq;
    logic [3:0]  nm;
    logic [3:0]  ops;
    logic        ext0_pin_enable;
    logic        addr_trap_route_sel;
    logic        wdog_route_sel;
    logic        restored_master;
    logic        core_take;
    logic        core_irq_req;
    logic [15:0] core_vector;
    logic        accept_busy;
    logic [1:0]  push_sel;
    logic        sp_dec;
    logic        status_master;
    logic        malfunction_reset;
    logic [7:0]  busy_cycles;
    logic [7:0]  push_count;
    logic [5:0]  push_order;
    int          miscompares;
    int          total_checks;
    int          cycles;
    pic_row_t    rows [7] = '{'{0, 15, 8'h3b, 8'h80, 16'hffe0}, '{0, 16, 8'h2c, 8'h01, 16'hffbe},
                              '{0, 23, 8'h2c, 8'h80, 16'hffb0}, '{1, 2, 8'h00, 8'h00, 16'hfffa},
                              '{2, 3, 8'h00, 8'h00, 16'hfff8}, '{3, 1, 8'h00, 8'h00, 16'hfffc},
                              '{4, 1, 8'h00, 8'h00, 16'hfffc}};
    logic [7:0]  addrs [6] = '{8'h2c, 8'h2e, 8'h3a, 8'h3b, 8'h3c, 8'h3d};

    pic_ctrl #(.MCYC_CLKS(MC)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .src_irq(src_irq),
        .addr_trap_irq(nm[0]), .wdog_irq(nm[1]), .soft_trap_irq(nm[2]), .illegal_opcode_irq(nm[3]),
        .ext0_pin_enable(ext0_pin_enable), .addr_trap_route_sel(addr_trap_route_sel),
        .wdog_route_sel(wdog_route_sel), .core_take(core_take), .set_master_op(ops[0]),
        .clear_master_op(ops[1]), .maskable_return_op(ops[2]), .nonmaskable_return_op(ops[3]),
        .restored_master(restored_master), .core_irq_req(core_irq_req), .core_vector(core_vector),
        .accept_busy(accept_busy), .push_sel(push_sel), .sp_dec(sp_dec), .status_master(status_master),
        .malfunction_reset(malfunction_reset));

    pic_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .core_irq_req(core_irq_req),
        .accept_busy(accept_busy), .push_sel(push_sel), .sp_dec(sp_dec), .core_take(core_take),
        .busy_cycles(busy_cycles), .push_count(push_count), .push_order(push_order));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk) #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge ref_clk) #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge ref_clk) #1;
        sfr_rd = 1'b0;
        chk(name, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask

    task automatic op(input int b);
        @(posedge ref_clk) #1;
        ops[b] = 1'b1;
        @(posedge ref_clk) #1;
        ops[b] = 1'b0;
    endtask

    // Latched sources are pulsed; the two trap levels stay up until their acceptance.
    task automatic fire(input logic [19:0] m, input logic [3:0] t);
        @(posedge ref_clk) #1;
        src_irq = m;
        nm = nm | t;
        @(posedge ref_clk) #1;
        src_irq = 20'h00000;
        nm[1:0] = 2'b00;
    endtask

    task automatic take(input logic [15:0] vec, input logic stat);
        int n;
        n = 0;
        while (accept_busy !== 1'b1 && n < 40) begin
            @(posedge ref_clk) #1;
            n++;
        end
        nm[3:2] = 2'b00;
        chk("accept seen", 16'h0001, {15'h0000, accept_busy});
        chk("vector", vec, core_vector);
        chk("saved master", {15'h0000, stat}, {15'h0000, status_master});
        while (accept_busy !== 1'b0 && n < 400) begin
            @(posedge ref_clk) #1;
            chk("vector held", vec, core_vector);
            n++;
        end
        chk("busy cycles", 16'(8 * MC), {8'h00, busy_cycles});
        chk("pushes", 16'h0003, {8'h00, push_count});
        chk("push order", 16'h001b, {10'h000, push_order});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        pic_row_t   r;
        logic [7:0] lad;
        int         n;
        {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, src_irq, nm, ops} = '0;
        {ext0_pin_enable, addr_trap_route_sel, wdog_route_sel, restored_master} = 4'h0;
        {miscompares, total_checks, cycles} = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            if (r.kind == 0) begin
                lad = r.idx < 8 ? 8'h3c : (r.idx < 16 ? 8'h3d : 8'h2e);
                wr(r.en_addr, r.en_data);
                fire(20'h00001 << (r.idx - 4), 4'h0);
                rd(lad, 8'h01 << (r.idx % 8), "latch set");
                chk("request with master clear", 16'h0000, {15'h0000, core_irq_req});
                op(0);
                take(r.vec, 1'b1);
                rd(lad, 8'h00, "latch after accept");
                rd(8'h3a, 8'h00, "master after accept");
                wr(r.en_addr, 8'h00);
            end else begin
                fire(20'h00000, 4'h1 << (r.kind - 1));
                take(r.vec, 1'b0);
            end
        end
        wr(8'h3a, 8'h10);
        fire(20'h00001, 4'h0);
        op(0);
        repeat (6) @(posedge ref_clk);
        #1;
        chk("request with pin disabled", 16'h0000, {15'h0000, core_irq_req});
        ext0_pin_enable = 1'b1;
        take(16'hfff6, 1'b1);
        wr(8'h3a, 8'h20);
        wr(8'h2c, 8'h10);
        fire(20'h10002, 4'h0);
        op(0);
        take(16'hfff4, 1'b1);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("request after accept", 16'h0000, {15'h0000, core_irq_req});
        restored_master = 1'b1;
        op(2);
        take(16'hffb6, 1'b1);
        op(3);
        restored_master = 1'b0;
        rd(8'h3a, 8'h21, "master restored");
        op(1);
        rd(8'h3a, 8'h20, "master cleared");
        wr(8'h3a, 8'h00);
        fire(20'h00004, 4'h0);
        rd(8'h3c, 8'h40, "latch low");
        fire(20'h00100, 4'h0);
        rd(8'h3d, 8'h10, "latch high set");
        wr(8'h3d, 8'hef);
        rd(8'h3d, 8'h00, "latch high clear");
        // Load clear keeps the two trap bits at one, while source seven requests in the same cycle.
        @(posedge ref_clk) #1;
        {sfr_addr, sfr_wdata, sfr_wr, src_irq} = {8'h3c, 8'h0c, 1'b1, 20'h00008};
        @(posedge ref_clk) #1;
        {sfr_wr, src_irq} = '0;
        rd(8'h3c, 8'h80, "set beats clear");
        wr(8'h3c, 8'hff);
        rd(8'h3c, 8'h80, "write one ignored");
        wr(8'h3c, 8'h0c);
        rd(8'h3c, 8'h00, "latch cleared");
        wr(8'h2c, 8'ha5);
        rd(8'h2c, 8'ha5, "enable ext");
        wr(8'h3b, 8'h3c);
        rd(8'h3b, 8'h3c, "enable high");
        wr(8'h3a, 8'hfe);
        rd(8'h3a, 8'hf0, "enable low");
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00, "unmapped");
        wr(8'h2e, 8'hff);
        rd(8'h2e, 8'h00, "latch ext write one");
        {addr_trap_route_sel, wdog_route_sel} = 2'b11;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            fire(20'h00000, 4'h1 << k);
            while (malfunction_reset !== 1'b1 && n < 4) begin
                @(posedge ref_clk) #1;
                n++;
            end
            chk("routed reset", 16'h0001, {15'h0000, malfunction_reset});
            rd(8'h3c, 8'h00, "routed latch");
        end
        fire(20'h00020, 4'h0);
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("busy in reset", 16'h0000, {15'h0000, accept_busy});
        #1 rst_n = 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i], 8'h00, "reset value");
        end
        final_report();
    end
endmodule
